// File: bdu_pkg.sv
// package: constants shared by both ends of the debug serial link
package bdu_pkg;
    localparam logic [7:0]  OP_HALT        = 8'h90;
    localparam logic [7:0]  OP_ACK_ON      = 8'hD5;
    localparam logic [7:0]  OP_ACK_OFF     = 8'hD6;
    localparam int          BIT_CYCLES     = 16;
    localparam int          CMD_BITS       = 8;
    localparam int          STEAL_WAIT     = 128;
    localparam int          SAMPLE_POINT   = 8;
    localparam int          LOW_ONE        = 4;
    localparam int          LOW_ZERO       = 13;
    localparam int          ACK_CYCLES     = 16;
    localparam logic [17:0] DBG_BASE       = 18'h3FF00;
    localparam logic [17:0] DBG_REG_LAST   = 18'h3FF0B;
    localparam logic [17:0] DBG_TOP        = 18'h3FFFF;
    localparam int          CLK_MHZ        = 125;
    localparam int          HW_RD_WAIT     = 150;
    localparam int          HW_WR_WAIT     = 150;
    localparam int          FW_RD_WAIT     = 48;
    localparam int          FW_WR_WAIT     = 36;
    localparam int          EXIT_WAIT      = 76;
endpackage

// File: bdu_if.sv
// interface: the single wire debug link between host and target
`timescale 1ns/10ps
interface bdu_if;
    logic host_out;
    logic host_oe;
    logic tgt_out;
    logic tgt_oe;
    wire  line_level = !((host_oe && !host_out) || (tgt_oe && !tgt_out));
    modport tgt  (input line_level, output tgt_out, output tgt_oe);
    modport host (input line_level, output host_out, output host_oe);
endinterface

// File: bdu_target.sv
// target end: command receiver, bus stealer and acknowledge
`timescale 1ns/10ps
module bdu_target #(
    parameter int STEAL = bdu_pkg::STEAL_WAIT
) (
    input  wire logic        clk_sys,       // system clock
    input  wire logic        rst_n,         // sync reset, active low
    input  wire logic        clk_en,        // freezes state when low
    bdu_if.tgt               link,          // debug serial pin
    input  wire logic        unit_enable,   // debug unit enabled
    input  wire logic        bus_free,      // processor leaves bus idle
    input  wire logic        mem_req,       // memory command pending
    input  wire logic        mem_multi,     // access needs several cycles
    input  wire logic        mem_dbg_reg,   // debug register command
    input  wire logic [17:0] mem_addr,      // requested address
    input  wire logic        mem_word,      // 16-bit access
    input  wire logic        entry_overlap, // pc inside firmware space
    input  wire logic [17:0] cpu_pc,        // processor program counter
    input  wire logic        user_rd,       // user program read
    input  wire logic [17:0] user_addr,     // user read address
    input  wire logic        exit_debug,    // resume from debug state
    output logic             debug_active,  // halted debug state
    output logic             ack_on,        // handshake enabled
    output logic             cpu_freeze,    // processor frozen
    output logic             bus_grant,     // access cycle strobe
    output logic             dbg_sel,       // debug resources enabled
    output logic [17:0]      bus_addr,      // access address
    output logic [17:0]      saved_pc,      // pc saved on entry
    output logic             user_block,    // user read suppressed
    output logic             map_top,       // debug map active
    output logic [7:0]       cmd_byte       // last received command
);
    initial begin
        if (STEAL < 1 || STEAL > 255) begin
            $error("steal wait out of range");
        end
    end

    typedef enum logic [1:0] {RX_IDLE, RX_BIT, RX_WAIT} bdu_rx_e;
    typedef enum logic [1:0] {AC_IDLE, AC_WAIT, AC_LOW} bdu_ac_e;

    logic       sync1_q, sync2_q, prev_q;
    bdu_rx_e    rx_q;
    bdu_ac_e    ac_q;
    logic [4:0] cnt_q;
    logic [3:0] nbit_q;
    logic [7:0] shift_q;
    logic [7:0] wait_q;
    logic [4:0] ack_cnt_q;
    logic       busy_q;
    logic       halt_pend_q;
    logic       oe_q;

    // own acknowledge pulse must not start a command
    wire fall      = prev_q && !sync2_q && (ac_q == AC_IDLE);
    wire sample    = (rx_q == RX_BIT) && (cnt_q == 5'(bdu_pkg::SAMPLE_POINT));
    wire bit_end   = (rx_q == RX_BIT) && (cnt_q == 5'(bdu_pkg::BIT_CYCLES - 1));
    wire last_bit  = nbit_q == 4'(bdu_pkg::CMD_BITS - 1);
    wire cmd_done  = bit_end && last_bit;
    wire [7:0] cmd = {shift_q[6:0], sync2_q};
    wire [7:0] got = shift_q;
    wire is_halt   = got == bdu_pkg::OP_HALT;
    wire is_ack_on = got == bdu_pkg::OP_ACK_ON;
    wire is_ack_off = got == bdu_pkg::OP_ACK_OFF;
    wire new_cmd   = (rx_q == RX_WAIT);
    wire halt_go   = new_cmd && is_halt && unit_enable;
    wire steal_now = wait_q >= 8'(STEAL - 1);
    wire take      = busy_q && (bus_free || steal_now);
    wire stall     = busy_q && (steal_now || (mem_multi && bus_free));
    wire [17:0] ea = mem_word ? {mem_addr[17:1], 1'b0} : mem_addr;
    wire in_regs   = (user_addr >= bdu_pkg::DBG_BASE)
                     && (user_addr <= bdu_pkg::DBG_REG_LAST);
    wire ack_fire  = (ac_q == AC_WAIT) && (ack_cnt_q == 5'd0);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q  <= 1'b1;
        end else if (clk_en) begin
            sync1_q <= link.line_level;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // receiver: the first bit starts on a falling edge, later bits at the bit timer end or on a fall past the sample point
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_q    <= RX_IDLE;
            cnt_q   <= 5'd0;
            nbit_q  <= 4'd0;
            shift_q <= 8'h00;
        end else if (clk_en) begin
            case (rx_q)
                RX_IDLE: begin
                    if (fall) begin
                        rx_q   <= RX_BIT;
                        cnt_q  <= 5'd1;
                        nbit_q <= 4'd0;
                    end
                end
                RX_BIT: begin
                    cnt_q <= cnt_q + 5'd1;
                    if (sample) begin
                        shift_q <= cmd;
                    end
                    if (bit_end) begin
                        rx_q   <= last_bit ? RX_WAIT : RX_IDLE;
                        nbit_q <= nbit_q + 4'd1;
                        if (!last_bit) begin
                            rx_q <= RX_BIT;
                            cnt_q <= 5'd0;
                        end
                    end
                    if (fall && cnt_q > 5'(bdu_pkg::SAMPLE_POINT)) begin
                        cnt_q <= 5'd1;
                        nbit_q <= nbit_q + 4'd1;
                        if (last_bit) begin
                            rx_q <= RX_WAIT;
                        end
                    end
                end
                RX_WAIT: rx_q <= RX_IDLE;
                default: rx_q <= RX_IDLE;
            endcase
        end
    end

    // mode state: handshake, debug state, saved pc
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ack_on       <= 1'b0;
            debug_active <= 1'b0;
            halt_pend_q  <= 1'b0;
            saved_pc     <= 18'h00000;
            cmd_byte     <= 8'h00;
            map_top      <= 1'b0;
        end else if (clk_en) begin
            if (new_cmd) begin
                cmd_byte <= got;
            end
            if (new_cmd && is_ack_on) begin
                ack_on <= 1'b1;
            end else if (new_cmd && is_ack_off) begin
                ack_on <= 1'b0;
            end
            halt_pend_q <= halt_go && !debug_active;
            if (halt_go && !debug_active) begin
                debug_active <= 1'b1;
                saved_pc <= entry_overlap ? cpu_pc + 18'd1 : cpu_pc;
            end else if (exit_debug) begin
                debug_active <= 1'b0;
            end
            map_top <= (halt_go && !debug_active)
                       || (debug_active && !exit_debug);
        end
    end

    // memory access by cycle stealing
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busy_q     <= 1'b0;
            wait_q     <= 8'h00;
            bus_grant  <= 1'b0;
            dbg_sel    <= 1'b0;
            bus_addr   <= 18'h00000;
            cpu_freeze <= 1'b0;
            user_block <= 1'b0;
        end else if (clk_en) begin
            bus_grant  <= take;
            dbg_sel    <= take && mem_dbg_reg;
            cpu_freeze <= stall;
            user_block <= user_rd && in_regs && !take;
            if (take) begin
                bus_addr <= ea;
                busy_q <= 1'b0;
                wait_q <= 8'h00;
            end else if (busy_q) begin
                wait_q <= wait_q + 8'h01;
            end else if (mem_req) begin
                busy_q <= 1'b1;
            end
        end
    end

    // acknowledge: 16 cycle low pulse after a gap
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ac_q      <= AC_IDLE;
            ack_cnt_q <= 5'd0;
            oe_q      <= 1'b0;
        end else if (clk_en) begin
            case (ac_q)
                AC_IDLE: begin
                    if (ack_on && (halt_pend_q
                        || (new_cmd && is_ack_on))) begin
                        ac_q      <= AC_WAIT;
                        ack_cnt_q <= 5'(bdu_pkg::ACK_CYCLES - 1);
                    end else if (!ack_on && new_cmd && is_ack_on) begin
                        ac_q      <= AC_WAIT;
                        ack_cnt_q <= 5'(bdu_pkg::ACK_CYCLES - 1);
                    end
                end
                AC_WAIT: begin
                    ack_cnt_q <= ack_cnt_q - 5'd1;
                    if (ack_fire) begin
                        ac_q      <= AC_LOW;
                        oe_q      <= 1'b1;
                        ack_cnt_q <= 5'(bdu_pkg::ACK_CYCLES - 1);
                    end
                end
                AC_LOW: begin
                    ack_cnt_q <= ack_cnt_q - 5'd1;
                    if (ack_cnt_q == 5'd0) begin
                        ac_q <= AC_IDLE;
                        oe_q <= 1'b0;
                    end
                end
                default: ac_q <= AC_IDLE;
            endcase
        end
    end

    assign link.tgt_out = 1'b0;
    assign link.tgt_oe  = oe_q;
endmodule

// File: bdu_host.sv
// host end: serial command sender with fixed wait and ack detection
`timescale 1ns/10ps
module bdu_host #(
    parameter int WAIT_CYC = bdu_pkg::HW_WR_WAIT
) (
    input  wire logic       clk_sys,    // system clock
    input  wire logic       rst_n,      // sync reset, active low
    input  wire logic       clk_en,     // freezes state when low
    bdu_if.host             link,       // debug serial pin
    input  wire logic       send,       // start one command
    input  wire logic [7:0] opcode,     // command byte
    input  wire logic       use_ack,    // record ack pulse during fixed wait
    output logic            busy,       // command in progress
    output logic            done,       // one-cycle completion pulse
    output logic            ack_seen    // last command was acked
);
    initial begin
        if (WAIT_CYC < 1 || WAIT_CYC > 1023) begin
            $error("wait out of range");
        end
    end

    typedef enum logic [1:0] {H_IDLE, H_BIT, H_WAIT} bdu_hs_e;

    bdu_hs_e    st_q;
    logic [4:0] cnt_q;
    logic [3:0] nbit_q;
    logic [7:0] sh_q;
    logic [9:0] gap_q;
    logic       s1_q, s2_q, p_q, drv_q;

    wire [4:0] low_len = sh_q[7] ? 5'(bdu_pkg::LOW_ONE)
                                 : 5'(bdu_pkg::LOW_ZERO);
    wire bit_end = cnt_q == 5'(bdu_pkg::BIT_CYCLES - 1);
    wire ack_low = p_q && !s2_q && !drv_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            p_q  <= 1'b1;
        end else if (clk_en) begin
            s1_q <= link.line_level;
            s2_q <= s1_q;
            p_q  <= s2_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q <= H_IDLE;
            cnt_q <= 5'd0;
            nbit_q <= 4'd0;
            sh_q <= 8'h00;
            gap_q <= 10'd0;
            drv_q <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            ack_seen <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            case (st_q)
                H_IDLE: begin
                    if (send) begin
                        st_q <= H_BIT;
                        sh_q <= opcode;
                        cnt_q <= 5'd0;
                        nbit_q <= 4'd0;
                        drv_q <= 1'b1;
                        busy <= 1'b1;
                        ack_seen <= 1'b0;
                    end
                end
                H_BIT: begin
                    cnt_q <= cnt_q + 5'd1;
                    if (cnt_q == low_len) begin
                        drv_q <= 1'b0;
                    end
                    if (bit_end) begin
                        cnt_q <= 5'd0;
                        nbit_q <= nbit_q + 4'd1;
                        sh_q <= {sh_q[6:0], 1'b0};
                        if (nbit_q == 4'(bdu_pkg::CMD_BITS - 1)) begin
                            st_q <= H_WAIT;
                            gap_q <= 10'(WAIT_CYC);
                        end else begin
                            drv_q <= 1'b1;
                        end
                    end
                end
                H_WAIT: begin
                    gap_q <= gap_q - 10'd1;
                    if (use_ack && ack_low) begin
                        ack_seen <= 1'b1;
                    end
                    if (gap_q == 10'd0) begin
                        st_q <= H_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign link.host_out = 1'b0;
    assign link.host_oe  = drv_q;
endmodule

// File: bdu_link_monitor_monitor.sv
// checker: framing and handshake rules watched on the debug link
`timescale 1ns/10ps
module bdu_link_monitor (
    input wire logic clk_sys,    // system clock
    input wire logic rst_n,      // sync reset, active low
    input wire logic host_out,   // host drive value
    input wire logic host_oe,    // host pulls line low
    input wire logic tgt_out,    // target drive value
    input wire logic tgt_oe,     // target pulls line low
    input wire logic line_level  // resolved line
);
    logic       host_oe_q;
    logic [7:0] since_q;
    logic [7:0] since_d;
    logic [3:0] bits_q;
    logic [3:0] bits_d;
    logic [7:0] idle_q;
    logic [7:0] idle_d;
    logic [4:0] low_q;
    wire        host_rise = host_oe && !host_oe_q;
    wire        new_frame = since_q > 8'd32;
    // counters: cycles since a bit start, bits in frame, idle; the first and last saturate
    assign since_d = host_rise ? 8'd1 : since_q + {7'h0, since_q != 8'hFF};
    assign bits_d  = !host_rise ? bits_q : new_frame ? 4'd1 : bits_q + 4'd1;
    assign idle_d  = host_oe ? 8'd0 : idle_q + {7'h0, idle_q != 8'hFF};
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            host_oe_q <= 1'b0;
            since_q   <= 8'hFF;
            bits_q    <= 4'd0;
            idle_q    <= 8'hFF;
            low_q     <= 5'h00;
        end else begin
            host_oe_q <= host_oe;
            // length of the current host low pulse, saturating
            low_q     <= host_oe ? low_q + {4'h0, low_q != 5'h1F} : 5'h00;
            since_q   <= since_d;
            bits_q    <= bits_d;
            idle_q    <= idle_d;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_low_width: assert property (host_oe_q && !host_oe |->
        (low_q == 5'h05) || (low_q == 5'h0E))
        else $error("host low pulse is neither one nor zero width");
    chk_bit_period: assert property (host_rise && !new_frame |->
        since_q == 8'd16) else $error("bit time is not sixteen cycles");
    chk_frame_eight: assert property (since_q == 8'd40 |->
        bits_q == 4'd8) else $error("frame does not hold eight bits");
    chk_host_polarity: assert property (host_oe |-> !host_out)
        else $error("host drives line high");
    chk_tgt_polarity: assert property (tgt_oe |-> !tgt_out)
        else $error("target drives line high");
    chk_idle_high: assert property (!host_oe && !tgt_oe |-> line_level)
        else $error("released line not high");
    chk_ack_width: assert property ($rose(tgt_oe) |-> tgt_oe[*8]
        ##1 tgt_oe[*8] ##1 !tgt_oe) else $error("ack pulse not 16 cycles");
    chk_ack_after_frame: assert property ($rose(tgt_oe) |->
        idle_q >= 8'd16) else $error("ack starts too soon after frame");
    chk_no_contention: assert property (!(host_oe && tgt_oe))
        else $error("both ends drive the line");

    cover property ($rose(tgt_oe));
    cover property (since_q == 8'd40 && bits_q == 4'd8);
    cover property (host_rise && since_q == 8'd16);
endmodule

// File: test_background_debug_hw_commands.sv
// testbench: host and target ends joined over the debug link
`timescale 1ns/10ps
module test_background_debug_hw_commands;
    localparam int STEAL = 4;
    logic clk_sys = 1'b0, rst_n = 1'b0, unit_enable = 1'b0, bus_free = 1'b1;
    logic mem_req = 1'b0, mem_multi = 1'b0, mem_dbg_reg = 1'b0;
    logic mem_word = 1'b1, entry_overlap = 1'b0, user_rd = 1'b0;
    logic exit_debug = 1'b0, send = 1'b0, use_ack = 1'b0;
    logic [17:0] mem_addr = 18'h0, cpu_pc = 18'h0, user_addr = 18'h0;
    logic [7:0]  opcode = 8'h0;
    logic debug_active, ack_on, cpu_freeze, bus_grant, dbg_sel;
    logic user_block, map_top, busy, done, ack_seen;
    logic [17:0] bus_addr, saved_pc;
    logic [7:0]  cmd_byte;
    int miscompares = 0, total_checks = 0, acks = 0, freezes = 0;

    bdu_if link ();
    always #4 clk_sys = ~clk_sys;
    always @(posedge link.tgt_oe) acks++;
    always @(posedge cpu_freeze) freezes++;

    bdu_target #(.STEAL(STEAL)) bdu_target_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .clk_en(1'b1), .link(link), .unit_enable(unit_enable),
        .bus_free(bus_free), .mem_req(mem_req), .mem_multi(mem_multi),
        .mem_dbg_reg(mem_dbg_reg), .mem_addr(mem_addr), .mem_word(mem_word),
        .entry_overlap(entry_overlap), .cpu_pc(cpu_pc), .user_rd(user_rd),
        .user_addr(user_addr), .exit_debug(exit_debug),
        .debug_active(debug_active), .ack_on(ack_on), .cpu_freeze(cpu_freeze),
        .bus_grant(bus_grant), .dbg_sel(dbg_sel), .bus_addr(bus_addr),
        .saved_pc(saved_pc), .user_block(user_block), .map_top(map_top),
        .cmd_byte(cmd_byte));
    bdu_host bdu_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
        .link(link), .send(send), .opcode(opcode), .use_ack(use_ack),
        .busy(busy), .done(done), .ack_seen(ack_seen));
    bdu_link_monitor bdu_link_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .host_out(link.host_out), .host_oe(link.host_oe),
        .tgt_out(link.tgt_out), .tgt_oe(link.tgt_oe),
        .line_level(link.line_level));

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk({17'h0, got}, {17'h0, exp});
    endtask
    task automatic cycles(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask
    task automatic send_cmd(input logic [7:0] op, input logic ack);
        int i;
        cycles(2);
        send = 1'b1;
        opcode = op;
        use_ack = ack;
        cycles(1);
        send = 1'b0;
        for (i = 0; i < 2000 && done !== 1'b1; i++) cycles(1);
        chk_b(done, 1'b1);
    endtask
    task automatic mem_op(input logic free, multi, dreg, input logic [17:0] a,
                          output int w, output logic fz, sel,
                          output logic [17:0] ba);
        bus_free = free;
        mem_multi = multi;
        mem_dbg_reg = dreg;
        mem_addr = a;
        mem_req = 1'b1;
        cycles(1);
        mem_req = 1'b0;
        for (w = 0; w < 300 && bus_grant !== 1'b1; w++) cycles(1);
        fz = cpu_freeze;
        sel = dbg_sel;
        ba = bus_addr;
        cycles(1);
        chk_b(dbg_sel, 1'b0);
        bus_free = 1'b1;
        cycles(2);
    endtask
    task automatic leave_debug;
        exit_debug = 1'b1;
        cycles(1);
        exit_debug = 1'b0;
        cycles(3);
        chk_b(debug_active, 1'b0);
        chk_b(map_top, 1'b0);
        cycles(bdu_pkg::EXIT_WAIT);
    endtask

    task automatic t_ack_on;
        send_cmd(bdu_pkg::OP_ACK_ON, 1'b1);
        chk_b(ack_seen, 1'b1);
        chk_b(ack_on, 1'b1);
        chk({10'h0, cmd_byte}, {10'h0, bdu_pkg::OP_ACK_ON});
    endtask
    task automatic t_halt_disabled;
        int f, a;
        f = freezes;
        a = acks;
        unit_enable = 1'b0;
        send_cmd(bdu_pkg::OP_HALT, 1'b0);
        chk_b(debug_active, 1'b0);
        chk(18'(freezes - f), 18'h0);
        chk(18'(acks - a), 18'h0);
    endtask
    task automatic t_halt_overlap;
        int a, w;
        logic fz, sel;
        logic [17:0] ba;
        a = acks;
        unit_enable = 1'b1;
        entry_overlap = 1'b1;
        cpu_pc = 18'h3FF80;
        send_cmd(bdu_pkg::OP_HALT, 1'b1);
        chk_b(debug_active, 1'b1);
        chk(18'(acks - a), 18'h1);
        chk_b(map_top, 1'b1);
        chk(saved_pc, 18'h3FF81);
        user_rd = 1'b1;
        user_addr = bdu_pkg::DBG_REG_LAST;
        cycles(3);
        chk_b(user_block, 1'b1);
        user_addr = 18'h01000;
        cycles(3);
        chk_b(user_block, 1'b0);
        user_rd = 1'b0;
        mem_op(1'b1, 1'b0, 1'b0, 18'h00456, w, fz, sel, ba);
        chk(ba, 18'h00456);
        cpu_pc = 18'h01000;
        leave_debug();
    endtask
    task automatic t_ack_off;
        int a;
        a = acks;
        send_cmd(bdu_pkg::OP_ACK_OFF, 1'b0);
        chk_b(ack_on, 1'b0);
        entry_overlap = 1'b0;
        cpu_pc = 18'h01234;
        send_cmd(bdu_pkg::OP_HALT, 1'b0);
        chk_b(debug_active, 1'b1);
        chk(saved_pc, 18'h01234);
        chk(18'(acks - a), 18'h0);
        leave_debug();
    endtask
    task automatic t_mem;
        int w;
        logic fz, sel;
        logic [17:0] ba;
        mem_op(1'b1, 1'b0, 1'b0, 18'h01235, w, fz, sel, ba);
        chk_b(w <= 2, 1'b1);
        chk_b(fz, 1'b0);
        chk(ba, 18'h01234);
        mem_op(1'b0, 1'b0, 1'b0, 18'h02000, w, fz, sel, ba);
        chk_b(w >= STEAL && w <= STEAL + 3, 1'b1);
        chk_b(fz, 1'b1);
        mem_op(1'b1, 1'b1, 1'b0, 18'h02002, w, fz, sel, ba);
        chk_b(fz, 1'b1);
        chk_b(sel, 1'b0);
        mem_op(1'b1, 1'b0, 1'b1, 18'h3FF02, w, fz, sel, ba);
        chk_b(sel, 1'b1);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        cycles(3);
        t_ack_on();
        t_halt_disabled();
        t_halt_overlap();
        t_ack_off();
        t_mem();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        conclude();
    end
endmodule
